// >>> eelc_pkg.sv
// Package for the edge event unit: sizes, line indices, reset values and carriers
package eelc_pkg;

  // Line counts and pin selection
  localparam int unsigned NUM_LINES = 19;
  localparam int unsigned NUM_EXT   = 16;
  localparam int unsigned NUM_PINS  = 51;
  localparam int unsigned SEL_W     = 6;

  // Internal source line indices
  localparam int unsigned LINE_SUPPLY = 16;
  localparam int unsigned LINE_RTC    = 17;
  localparam int unsigned LINE_USB    = 18;

  // Synchroniser depth (two flops before the edge detect logic; the wake path uses the raw toggles)
  localparam int unsigned SYNC_STAGES = 2;

  // Values after reset
  localparam logic [NUM_LINES-1:0] LINES_RST = 19'h00000;
  localparam logic [SEL_W-1:0]     SEL_ZERO  = 6'h00;

  // Per-line configuration carrier
  typedef struct packed {
    logic [NUM_LINES-1:0] rise_en;  // Rising edge triggers
    logic [NUM_LINES-1:0] fall_en;  // Falling edge triggers
    logic [NUM_LINES-1:0] int_en;   // Interrupt unmasked
    logic [NUM_LINES-1:0] evt_en;   // Event unmasked
  } eelc_cfg_s;

  // Pin select for one external line
  typedef logic [SEL_W-1:0] eelc_sel_t;

endpackage : eelc_pkg

// >>> eelc_edge_event_unit.sv
// Edge event unit: 19 asynchronously captured edge lines with masks and pending bits
// What this block does
// [R01] Nineteen independent edge lines, each raising an interrupt or event request.
// [R02] Each line picks rising, falling or both edges on its own.
// [R03] Each line has its own mask; a masked edge gives no request.
// [R04] Pending bit per line set on an edge with its interrupt unmasked, held until cleared.
// [R05] Edges captured asynchronously, so pulses shorter than a clock are kept.
// [R06] Sixteen external lines, each selecting one of fifty-one pins.
// [R07] Other lines fed by supply monitor, clock alarm and USB wake-up.
// [R08] Any line can request wake-up while the bus clock is stopped.
// [R09] Software clears a pending bit before a later edge counts anew.
`timescale 1ns/1ps

module eelc_edge_event_unit (
  // Clock and reset
  input  wire logic                                   i_core_clk,
  input  wire logic                                   i_reset_n,
  // Sources
  input  wire logic [eelc_pkg::NUM_PINS-1:0]          i_gpio_pins,
  input  wire logic                                   i_supply_level_monitor,
  input  wire logic                                   i_rtc_alarm,
  input  wire logic                                   i_usb_wakeup,
  // Configuration
  input  wire eelc_pkg::eelc_sel_t                    i_pin_sel [eelc_pkg::NUM_EXT],
  input  wire eelc_pkg::eelc_cfg_s                    i_cfg,
  input  wire logic [eelc_pkg::NUM_LINES-1:0]         i_pend_clr,
  // Requests and status
  output logic      [eelc_pkg::NUM_LINES-1:0]         o_pending,
  output logic      [eelc_pkg::NUM_LINES-1:0]         o_irq,
  output logic      [eelc_pkg::NUM_LINES-1:0]         o_event,
  output logic                                        o_wake_req
);

  localparam int unsigned NL = eelc_pkg::NUM_LINES;

  // Pin mux with out-of-range selects reading low
  function automatic logic pick_pin(input logic [eelc_pkg::NUM_PINS-1:0] pins,
                                    input eelc_pkg::eelc_sel_t           sel);
    logic res;
    res = 1'b0;
    if (int'(sel) < int'(eelc_pkg::NUM_PINS))
      res = pins[sel];
    return res;
  endfunction : pick_pin

  logic [NL-1:0] line_src;
  logic [NL-1:0] tog_rise;
  logic [NL-1:0] tog_fall;

  // Source routing onto the lines; a select change may fake an edge
  always_comb
  begin
    line_src = '0;
    for (int i = 0; i < int'(eelc_pkg::NUM_EXT); i++)
      line_src[i] = pick_pin(i_gpio_pins, i_pin_sel[i]);               // [R06]
    line_src[eelc_pkg::LINE_SUPPLY] = i_supply_level_monitor;           // [R07]
    line_src[eelc_pkg::LINE_RTC]    = i_rtc_alarm;                      // [R07]
    line_src[eelc_pkg::LINE_USB]    = i_usb_wakeup;                     // [R07]
  end

  // Edge toggles clocked by the line itself, so no core clock is needed
  for (genvar g = 0; g < NL; g++) begin : g_cap
    logic rise_r;
    logic fall_r;
    always_ff @(posedge line_src[g] or negedge i_reset_n)
    begin
      if (!i_reset_n)
        rise_r <= 1'b0;
      else
        rise_r <= ~rise_r;                                              // [R05]
    end
    always_ff @(negedge line_src[g] or negedge i_reset_n)
    begin
      if (!i_reset_n)
        fall_r <= 1'b0;
      else
        fall_r <= ~fall_r;                                              // [R05]
    end
    assign tog_rise[g] = rise_r;
    assign tog_fall[g] = fall_r;
  end

  // Synchroniser and edge history state
  logic [NL-1:0] rs1_r, rs2_r, rprev_r;
  logic [NL-1:0] fs1_r, fs2_r, fprev_r;
  logic [NL-1:0] rs1_nxt, rs2_nxt, rprev_nxt;
  logic [NL-1:0] fs1_nxt, fs2_nxt, fprev_nxt;

  always_comb
  begin
    rs1_nxt   = tog_rise;
    rs2_nxt   = rs1_r;
    rprev_nxt = rs2_r;
    fs1_nxt   = tog_fall;
    fs2_nxt   = fs1_r;
    fprev_nxt = fs2_r;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rs1_r   <= eelc_pkg::LINES_RST;
      rs2_r   <= eelc_pkg::LINES_RST;
      rprev_r <= eelc_pkg::LINES_RST;
      fs1_r   <= eelc_pkg::LINES_RST;
      fs2_r   <= eelc_pkg::LINES_RST;
      fprev_r <= eelc_pkg::LINES_RST;
    end
    else
    begin
      rs1_r   <= rs1_nxt;
      rs2_r   <= rs2_nxt;
      rprev_r <= rprev_nxt;
      fs1_r   <= fs1_nxt;
      fs2_r   <= fs2_nxt;
      fprev_r <= fprev_nxt;
    end
  end

  // Edge hits per line after trigger selection
  logic [NL-1:0] hit;
  logic [NL-1:0] int_req;
  logic [NL-1:0] evt_req;

  always_comb
  begin
    hit     = ((rs2_r ^ rprev_r) & i_cfg.rise_en) |
              ((fs2_r ^ fprev_r) & i_cfg.fall_en);                      // [R02]
    int_req = hit & i_cfg.int_en;                                       // [R03]
    evt_req = hit & i_cfg.evt_en;                                       // [R03]
  end

  // Pending, interrupt and event outputs
  logic [NL-1:0] pend_r, pend_nxt;
  logic [NL-1:0] irq_r, irq_nxt;
  logic [NL-1:0] evt_r, evt_nxt;

  always_comb
  begin
    pend_nxt = (pend_r & ~i_pend_clr) | int_req;                        // [R04]
    irq_nxt  = pend_nxt & i_cfg.int_en;                                 // [R01]
    evt_nxt  = evt_req;                                                 // [R01]
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pend_r <= eelc_pkg::LINES_RST;
      irq_r  <= eelc_pkg::LINES_RST;
      evt_r  <= eelc_pkg::LINES_RST;
    end
    else
    begin
      pend_r <= pend_nxt;
      irq_r  <= irq_nxt;
      evt_r  <= evt_nxt;
    end
  end

  assign o_pending = pend_r;
  assign o_irq     = irq_r;
  assign o_event   = evt_r;

  // Wake request compares live toggles with the last seen copy; stays up with no clock
  assign o_wake_req = |((((tog_rise ^ rprev_r) & i_cfg.rise_en) |
                         ((tog_fall ^ fprev_r) & i_cfg.fall_en)) &
                        (i_cfg.int_en | i_cfg.evt_en));                 // [R08]

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  property p_pend_set;
    int_req != '0 |=> (o_pending & $past(int_req)) == $past(int_req);
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not set on request"); // [R04]

  property p_set_wins;
    (int_req & i_pend_clr) != '0 |=> (o_pending & $past(int_req & i_pend_clr)) != '0;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge"); // [R04]

  property p_clear;
    (i_pend_clr & ~int_req & o_pending) != '0 |=>
      (o_pending & $past(i_pend_clr & ~int_req)) == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("pending bit not cleared"); // [R09]

  property p_no_spurious;
    ((o_pending & ~$past(o_pending)) & ~$past(int_req)) == '0;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("pending set without edge"); // [R03]

  property p_irq_mask;
    o_irq == (o_pending & $past(i_cfg.int_en));
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt ignores mask"); // [R01]

  property p_evt_cause;
    o_event == $past(hit & i_cfg.evt_en);
  endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without masked edge"); // [R03]

  property p_trig_sel;
    (hit & ~(i_cfg.rise_en | i_cfg.fall_en)) == '0;
  endproperty
  a_trig_sel: assert property (p_trig_sel) else $error("hit on line with no edge chosen"); // [R02]

  property p_rise_latency;
    $rose(rs2_r[0]) && i_cfg.rise_en[0] && i_cfg.int_en[0] |=> o_pending[0];
  endproperty
  a_rise_latency: assert property (p_rise_latency) else $error("line 0 edge not pending"); // [R05]

  property p_pin_route;
    int'(i_pin_sel[0]) < int'(eelc_pkg::NUM_PINS) |-> line_src[0] == i_gpio_pins[i_pin_sel[0]];
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("line 0 pin route wrong"); // [R06]

  c_pending: cover property (o_pending != '0);
  c_both: cover property (hit[0] && i_cfg.rise_en[0] && i_cfg.fall_en[0]);
  c_set_clr: cover property ((int_req & i_pend_clr) != '0);
  c_usb: cover property (o_pending[eelc_pkg::LINE_USB]);

endmodule : eelc_edge_event_unit

// >>> eelc_src_model.sv
// Source model: drives one chosen pin or internal source to a level
`timescale 1ns/1ps
module eelc_src_model (
  // Control from the bench
  input  wire logic       i_level,
  input  wire logic [4:0] i_line,
  input  wire logic [5:0] i_pin,
  // Sources toward the unit
  output logic [50:0]     o_pins,
  output logic            o_supply,
  output logic            o_rtc,
  output logic            o_usb
);
  // Route the level to a pin for external lines, else to an internal source
  always_comb
  begin
    o_pins = '0;
    if (i_line < 5'h10)
      o_pins[i_pin] = i_level;
    o_supply = (i_line == 5'h10) & i_level;
    o_rtc    = (i_line == 5'h11) & i_level;
    o_usb    = (i_line == 5'h12) & i_level;
  end
endmodule : eelc_src_model

// >>> tb_top.sv
// Testbench: random edge, mask and pin-select checks on the edge event unit
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, lvl = 1'b0, ri, fa, ie, ee, wk;
  logic [4:0] line = '0;
  logic [5:0] pin = '0;
  logic [50:0] pins;
  logic sup, rtc, usb, wake;
  logic [18:0] clr = '0, pend, irq, evt;
  eelc_pkg::eelc_sel_t sel [eelc_pkg::NUM_EXT];
  eelc_pkg::eelc_cfg_s cfg = '0;
  int mismatches = 0, n_checks = 0, nev = 0, seed = 32'h4E6C67A2;
  // Clock and edge watchers
  always #12.5 clk = ~clk;
  // Event pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk) if (evt[line] === 1'b1) nev++;
  always @(posedge wake) wk = 1'b1;
  eelc_src_model PM (.i_level(lvl), .i_line(line), .i_pin(pin), .o_pins(pins),
    .o_supply(sup), .o_rtc(rtc), .o_usb(usb));
  eelc_edge_event_unit DUT (.i_core_clk(clk), .i_reset_n(rst_n), .i_gpio_pins(pins),
    .i_supply_level_monitor(sup), .i_rtc_alarm(rtc), .i_usb_wakeup(usb), .i_pin_sel(sel),
    .i_cfg(cfg), .i_pend_clr(clr), .o_pending(pend), .o_irq(irq), .o_event(evt), .o_wake_req(wake));
  // Compare and count
  task automatic check(input logic [18:0] got, input logic [18:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic conclude();
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // Whether the applied edge should count on the chosen line
  function automatic logic counts(input logic up, input logic narrow);
    return narrow ? (ri | fa) : (up ? ri : fa);
  endfunction : counts
  // One edge or narrow pulse, then status checks and a clear
  task automatic hit(input logic up, input logic narrow);
    logic en;
    logic [18:0] exp;
    en = counts(up, narrow);
    exp = (en & ie) ? (19'h00001 << line) : 19'h00000;
    nev = 0;
    wk = 1'b0;
    lvl = narrow | up;
    if (narrow)
      #5 lvl = 1'b0;
    repeat (6) @(posedge clk);
    #2;
    check(pend, exp);
    check(irq, exp);
    check({18'h00000, nev != 0}, {18'h00000, en & ee});
    check({18'h00000, wk}, {18'h00000, en & (ie | ee)});
    clr = '1;
    @(posedge clk);
    #2 clr = '0;
    @(posedge clk);
    #2 check(pend, 19'h00000);
    check(irq, 19'h00000);
  endtask : hit
  // Reset, then random lines, sources, masks and edge choices
  initial
  begin
    foreach (sel[k]) sel[k] = eelc_pkg::SEL_ZERO;
    repeat (5) @(posedge clk);
    #2 rst_n = 1'b1;
    check(pend, eelc_pkg::LINES_RST);
    for (int k = 0; k < 60; k++)
    begin
      line = (k < 3) ? 5'(16 + k) : 5'($unsigned($random(seed)) % 19);
      pin = 6'($unsigned($random(seed)) % 51);
      cfg = 76'({$random(seed), $random(seed), $random(seed)});
      // Park every external line on an unused select so only the chosen line sees the pin
      foreach (sel[j]) sel[j] = 6'h3F;
      if (line < 5'h10)
        sel[line[3:0]] = pin;
      {ri, fa, ie, ee} = {cfg.rise_en[line], cfg.fall_en[line], cfg.int_en[line], cfg.evt_en[line]};
      repeat (3) @(posedge clk);
      #2;
      if ($random(seed) & 1)
        hit(1'b1, 1'b1);
      else
      begin
        hit(1'b1, 1'b0);
        hit(1'b0, 1'b0);
      end
    end
    // Corner: the clear lands in the same cycle as the new edge, and the set must win
    line = 5'h10;
    cfg = '1;
    repeat (3) @(posedge clk);
    #2 lvl = 1'b1;
    repeat (2) @(posedge clk);
    #2 clr = '1;
    @(posedge clk);
    #2 clr = '0;
    check(pend, 19'h00001 << line);
    conclude();
  end
  // Watchdog against a hang
  initial
  begin
    #400000;
    mismatches++;
    conclude();
  end
endmodule : tb_top
